/* File: common/timer_watchdog_pkg.sv */
`default_nettype none
package timer_watchdog_pkg;
   // register file addresses
   localparam logic [7:0] ADDR_VECTOR_SELECT = 8'hf6;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'hf8;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'hf9;
   localparam logic [7:0] ADDR_PRESCALE = 8'hfa;
   localparam logic [7:0] ADDR_CONTROL = 8'hfb;
   localparam logic [7:0] ADDR_WAIT_CONTROL = 8'hfc;
   // reset values
   localparam logic [7:0] CONTROL_RESET = 8'h12;
   localparam logic [7:0] WAIT_CONTROL_RESET = 8'h7f;
   localparam logic [7:0] VECTOR_SELECT_RESET = 8'h06;
   localparam logic [15:0] COUNT_RESET = 16'hffff;
   localparam logic [7:0] PRESCALE_RESET = 8'hff;
   // field positions
   localparam int RUN_POS = 7;
   localparam int SINGLE_POS = 6;
   localparam int MODE_HI_POS = 5;
   localparam int MODE_LO_POS = 4;
   localparam int IN_EN_POS = 3;
   localparam int OUT_MODE_POS = 2;
   localparam int OUT_LEVEL_POS = 1;
   localparam int OUT_EN_POS = 0;
   localparam int GUARD_POS = 6;
   localparam int TOP_SEL_POS = 2;
   localparam int A0_SEL_POS = 1;
   // servicing codes
   localparam logic [7:0] SERVICE_FIRST = 8'haa;
   localparam logic [7:0] SERVICE_SECOND = 8'h55;
   // internal counting clock divider
   localparam int CLOCK_DIVIDE = 4;
   localparam logic [1:0] DIV_LAST = 2'(CLOCK_DIVIDE - 1);
   // input modes {input_mode_high, input_mode_low}
   typedef enum logic [1:0] {
      MODE_EVENT = 2'b00,
      MODE_GATED = 2'b01,
      MODE_TRIGGER = 2'b10,
      MODE_RETRIGGER = 2'b11
   } input_mode_e;
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_write_s;
   typedef struct packed {
      logic top_level;
      logic channel_a0;
      logic soft_trap;
   } irq_route_s;
endpackage : timer_watchdog_pkg
`default_nettype wire

/* File: verilog/timer_watchdog_unit.sv */
`default_nettype none
module timer_watchdog_unit (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire timer_watchdog_pkg::reg_write_s reg_wr,
   input wire logic [7:0] reg_addr,
   output logic [7:0] reg_rdata,
   input wire logic timer_in_pin,
   input wire logic nmi_pin,
   input wire logic ext_a0_pin,
   output logic timer_out_pin,
   output logic timer_out_oe,
   output logic top_level_irq,
   output logic channel_a0_irq,
   output logic soft_trap_pend,
   output logic system_reset_req,
   output logic end_of_count
);
   logic [7:0] control_q;
   logic guard_mode_enable_n_q;
   logic [1:0] vector_sel_q;
   logic [15:0] const_q;
   logic [7:0] pre_const_q;
   logic [15:0] count_q;
   logic [7:0] pre_count_q;
   logic [1:0] div_q;
   logic const_dirty_q;
   logic first_code_q;
   logic out_q;
   logic pin_s1_q, pin_s2_q, pin_s3_q;
   logic nmi_s1_q, nmi_s2_q, a0_s1_q, a0_s2_q;
   logic [7:0] rdata_d;

   wire logic guard = ~guard_mode_enable_n_q;
   wire logic count_run_bit = control_q[timer_watchdog_pkg::RUN_POS];
   wire logic single_mode = control_q[timer_watchdog_pkg::SINGLE_POS];
   wire logic input_section_enable = control_q[timer_watchdog_pkg::IN_EN_POS];
   wire logic output_mode_bit = control_q[timer_watchdog_pkg::OUT_MODE_POS];
   wire logic output_level_bit = control_q[timer_watchdog_pkg::OUT_LEVEL_POS];
   wire logic output_drive_enable = control_q[timer_watchdog_pkg::OUT_EN_POS];
   wire timer_watchdog_pkg::input_mode_e in_mode = timer_watchdog_pkg::input_mode_e'(
      {control_q[timer_watchdog_pkg::MODE_HI_POS], control_q[timer_watchdog_pkg::MODE_LO_POS]});

   // register decodes
   wire logic wr_ctrl = reg_wr.wr && reg_wr.addr == timer_watchdog_pkg::ADDR_CONTROL;
   wire logic wr_high = reg_wr.wr && reg_wr.addr == timer_watchdog_pkg::ADDR_COUNT_HIGH;
   wire logic wr_low = reg_wr.wr && reg_wr.addr == timer_watchdog_pkg::ADDR_COUNT_LOW;
   wire logic wr_pre = reg_wr.wr && reg_wr.addr == timer_watchdog_pkg::ADDR_PRESCALE;
   wire logic wr_wait = reg_wr.wr && reg_wr.addr == timer_watchdog_pkg::ADDR_WAIT_CONTROL;
   wire logic wr_vec = reg_wr.wr && reg_wr.addr == timer_watchdog_pkg::ADDR_VECTOR_SELECT;
   wire logic const_wr = ~guard && (wr_high || wr_low);
   wire logic service = guard && wr_low && first_code_q
      && reg_wr.data == timer_watchdog_pkg::SERVICE_SECOND;
   wire logic run_set = wr_ctrl && reg_wr.data[timer_watchdog_pkg::RUN_POS] && ~count_run_bit;
   wire logic fall = pin_s3_q && ~pin_s2_q;
   wire logic div_tick = div_q == timer_watchdog_pkg::DIV_LAST;

   // input modes decide what a counting clock is
   wire logic inputs_on = input_section_enable && ~guard;
   wire logic event_mode = inputs_on && in_mode == timer_watchdog_pkg::MODE_EVENT;
   wire logic gated_mode = inputs_on && in_mode == timer_watchdog_pkg::MODE_GATED;
   wire logic trig_mode = inputs_on && in_mode == timer_watchdog_pkg::MODE_TRIGGER;
   wire logic retrig_mode = inputs_on && in_mode == timer_watchdog_pkg::MODE_RETRIGGER;
   wire logic retrig_start = retrig_mode && fall && ~count_run_bit;
   wire logic running = guard || count_run_bit;
   wire logic tick = running && (event_mode ? fall :
      (div_tick && (~gated_mode || pin_s2_q)));
   wire logic retrigger = trig_mode && count_run_bit && fall;
   wire logic pre_zero = pre_count_q == 8'h00;
   wire logic eoc = tick && pre_zero && count_q == 16'h0000;
   wire logic single_stop = eoc && ~guard && single_mode;

   // next run bit: hardware clear on single stop loses to a software set
   wire logic run_d = wr_ctrl ? (reg_wr.data[timer_watchdog_pkg::RUN_POS] && ~guard)
      || (count_run_bit && guard) : (retrig_start || (count_run_bit && ~single_stop));
   wire logic [7:0] control_d = wr_ctrl && ~guard ? {run_d, reg_wr.data[6:0]} :
      {run_d, control_q[6:0]};
   wire logic [15:0] const_d = wr_high ? {reg_wr.data, const_q[7:0]} :
      {const_q[15:8], reg_wr.data};

   // reload: new constant always at eoc in continuous/watchdog, changed-only in single
   wire logic reload_now = service || retrigger || retrig_start
      || (eoc && (~single_stop || const_dirty_q));
   wire logic stopped_load = const_wr && ~count_run_bit;

   wire timer_watchdog_pkg::irq_route_s route = '{
      top_level: vector_sel_q[1] ? nmi_s2_q : (eoc && ~guard),
      channel_a0: vector_sel_q[0] ? a0_s2_q : (eoc && ~guard),
      soft_trap: guard && (~vector_sel_q[1] || ~vector_sel_q[0])};

   always_comb begin
      unique case (reg_addr)
         timer_watchdog_pkg::ADDR_CONTROL: rdata_d = control_q;
         timer_watchdog_pkg::ADDR_COUNT_HIGH: rdata_d = count_q[15:8];
         timer_watchdog_pkg::ADDR_COUNT_LOW: rdata_d = count_q[7:0];
         timer_watchdog_pkg::ADDR_PRESCALE: rdata_d = pre_const_q;
         timer_watchdog_pkg::ADDR_WAIT_CONTROL:
            rdata_d = timer_watchdog_pkg::WAIT_CONTROL_RESET
               & ~(8'h01 << timer_watchdog_pkg::GUARD_POS)
               | ({7'h00, guard_mode_enable_n_q} << timer_watchdog_pkg::GUARD_POS);
         timer_watchdog_pkg::ADDR_VECTOR_SELECT: rdata_d = {5'h00, vector_sel_q, 1'b0};
         default: rdata_d = 8'h00;
      endcase
   end

   // pins are asynchronous: two flops each, then a third on the timer input for edge detection
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         {pin_s1_q, pin_s2_q, pin_s3_q} <= 3'h7;
         {nmi_s1_q, nmi_s2_q, a0_s1_q, a0_s2_q} <= 4'h0;
      end else if (clk_en) begin
         {pin_s1_q, pin_s2_q, pin_s3_q} <= {timer_in_pin, pin_s1_q, pin_s2_q};
         {nmi_s1_q, nmi_s2_q, a0_s1_q, a0_s2_q} <= {nmi_pin, nmi_s1_q, ext_a0_pin, a0_s1_q};
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         control_q <= timer_watchdog_pkg::CONTROL_RESET;
         guard_mode_enable_n_q <= 1'b1;
         vector_sel_q <= timer_watchdog_pkg::VECTOR_SELECT_RESET[2:1];
         const_q <= timer_watchdog_pkg::COUNT_RESET;
         pre_const_q <= timer_watchdog_pkg::PRESCALE_RESET;
         const_dirty_q <= 1'b0;
         first_code_q <= 1'b0;
      end else if (clk_en) begin
         control_q <= control_d;
         if (wr_wait && !reg_wr.data[timer_watchdog_pkg::GUARD_POS])
            guard_mode_enable_n_q <= 1'b0;
         if (wr_vec)
            vector_sel_q <= reg_wr.data[timer_watchdog_pkg::TOP_SEL_POS:timer_watchdog_pkg::A0_SEL_POS];
         if (const_wr)
            const_q <= const_d;
         if (wr_pre)
            pre_const_q <= reg_wr.data;
         if (stopped_load)
            const_dirty_q <= 1'b1;
         else if (reload_now || run_set)
            const_dirty_q <= 1'b0;
         if (guard && wr_low)
            first_code_q <= reg_wr.data == timer_watchdog_pkg::SERVICE_FIRST;
      end
   end

   // counter datapath
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= timer_watchdog_pkg::COUNT_RESET;
         pre_count_q <= timer_watchdog_pkg::PRESCALE_RESET;
         div_q <= 2'h0;
      end else if (clk_en) begin
         div_q <= running ? div_q + 2'h1 : 2'h0;
         if (reload_now || (stopped_load && ~tick)) begin
            count_q <= stopped_load ? const_d : const_q;
            pre_count_q <= pre_const_q;
         end else if (tick && !single_stop) begin
            pre_count_q <= pre_zero ? pre_const_q : pre_count_q - 8'h01;
            if (pre_zero)
               count_q <= count_q - 16'h0001;
         end
      end
   end

   // outputs
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         out_q <= 1'b1;
         reg_rdata <= 8'h00;
         end_of_count <= 1'b0;
         top_level_irq <= 1'b0;
         channel_a0_irq <= 1'b0;
         soft_trap_pend <= 1'b0;
         system_reset_req <= 1'b0;
         timer_out_pin <= 1'b1;
         timer_out_oe <= 1'b0;
      end else if (clk_en) begin
         if (eoc)
            out_q <= output_mode_bit ? output_level_bit : ~out_q;
         reg_rdata <= rdata_d;
         end_of_count <= eoc;
         top_level_irq <= route.top_level;
         channel_a0_irq <= route.channel_a0;
         soft_trap_pend <= route.soft_trap;
         system_reset_req <= eoc && guard;
         timer_out_pin <= output_drive_enable ? out_q : 1'b1;
         timer_out_oe <= 1'b1;
      end
   end

   a_run_clears_single: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && single_stop && !wr_ctrl |=> !count_run_bit)
      else $error("single mode did not clear run bit");
   a_guard_sticky: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && guard |=> guard) else $error("watchdog mode left");
   a_guard_reset: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && eoc && guard |=> system_reset_req) else $error("no watchdog reset");
   a_timer_no_reset: assert property (@(posedge clock) disable iff (!rst_n)
      !guard |=> !system_reset_req) else $error("reset outside watchdog");
   a_stopped_hold: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && !running && !reg_wr.wr && !retrig_start |=> $stable(count_q))
      else $error("count moved");
   a_drive_off_high: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && !output_drive_enable |=> timer_out_pin) else $error("pin not high");
   a_toggle_out: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && eoc && !output_mode_bit |=> out_q != $past(out_q))
      else $error("no toggle");
   a_irq_timer: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && eoc && !guard && !vector_sel_q[1] |=> top_level_irq)
      else $error("missing interrupt");
   a_service_reload: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && service |=> count_q == $past(const_q)) else $error("service no reload");
   a_trigger_ignored: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && trig_mode && !count_run_bit && !reg_wr.wr |=> $stable(count_q))
      else $error("trigger while stopped");

   // software start lands one cycle after the write
   a_run_sets_bit: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && wr_ctrl && reg_wr.data[timer_watchdog_pkg::RUN_POS] && !guard
      |=> count_run_bit) else $error("run bit not set");

   // software stop clears the run bit one cycle after the write
   a_stop_clears_bit: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && wr_ctrl && !reg_wr.data[timer_watchdog_pkg::RUN_POS] && !guard
      |=> !count_run_bit) else $error("run bit not cleared");

   // a constant written while stopped replaces the held count
   a_stopped_load: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && const_wr && !count_run_bit |=> count_q == $past(const_d))
      else $error("stopped write not loaded");

   // every timer-mode byte write reaches the constant
   a_const_update: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && const_wr |=> const_q == $past(const_d))
      else $error("constant not updated");

   // continuous mode reloads and keeps the run bit
   a_continuous_reload: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && eoc && !single_mode && count_run_bit && !wr_ctrl
      |=> count_run_bit && count_q == $past(const_q)) else $error("no continuous reload");

   // single mode reloads only a constant changed while stopped
   a_single_reload: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && single_stop && const_dirty_q |=> count_q == $past(const_q))
      else $error("single mode did not reload");

   // without a change the stopped count must not wrap
   a_single_hold: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && single_stop && !const_dirty_q && !retrigger |=> $stable(count_q))
      else $error("single mode count moved");

   // input section off: internal divided clock only
   a_inputs_off: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && !input_section_enable && !guard |-> tick == (count_run_bit && div_tick))
      else $error("input bits not ignored");

   // event mode counts falling edges only
   a_event_fall: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && event_mode |-> tick == (count_run_bit && fall))
      else $error("event tick wrong");

   // gated mode pauses while the pin is low
   a_gated_low: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && gated_mode && !pin_s2_q |-> !tick)
      else $error("gated tick while low");

   // gated mode follows the divided clock while the pin is high
   a_gated_high: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && gated_mode && pin_s2_q |-> tick == (count_run_bit && div_tick))
      else $error("gated tick wrong");

   // a falling edge starts a stopped retriggerable counter
   a_retrig_start: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && retrig_mode && fall && !count_run_bit && !wr_ctrl |=> count_run_bit)
      else $error("retrigger did not start");

   // in trigger mode a falling edge while running restarts from the constant
   a_trigger_restart: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && retrigger |=> count_q == $past(const_q))
      else $error("trigger did not restart");

   // clearing the enable bit enters watchdog mode
   a_guard_entry: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && wr_wait && !reg_wr.data[timer_watchdog_pkg::GUARD_POS] |=> guard)
      else $error("watchdog not entered");

   // watchdog always counts the divided clock
   a_guard_runs: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && guard |-> tick == div_tick)
      else $error("watchdog tick wrong");

   // the count constant is frozen once the watchdog runs
   a_guard_const_locked: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && guard |=> const_q == $past(const_q))
      else $error("watchdog constant changed");

   // control bits other than the output bits are don't-care, and all are locked in watchdog mode
   a_guard_control_locked: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && guard |=> control_q == $past(control_q))
      else $error("watchdog control changed");

   // the prescaler constant stays writable in every mode
   a_prescale_write: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && wr_pre |=> pre_const_q == $past(reg_wr.data))
      else $error("prescaler not written");

   // watchdog service is two writes to the low byte, any number of cycles apart with no other low-byte write between
   sequence s_first_code;
      clk_en && guard && wr_low && reg_wr.data == timer_watchdog_pkg::SERVICE_FIRST;
   endsequence : s_first_code
   sequence s_second_code;
      clk_en && wr_low && reg_wr.data == timer_watchdog_pkg::SERVICE_SECOND;
   endsequence : s_second_code

   a_service_pair: assert property (@(posedge clock) disable iff (!rst_n)
      s_first_code ##1 s_second_code |=> count_q == $past(const_q))
      else $error("back to back service ignored");

   // a gap between the two codes is allowed
   a_service_gap: assert property (@(posedge clock) disable iff (!rst_n)
      s_first_code ##1 (clk_en && !wr_low) ##1 s_second_code |=> count_q == $past(const_q))
      else $error("spaced service ignored");

   // level mode copies the software bit at end of count
   a_level_copy: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && eoc && output_mode_bit |=> out_q == $past(output_level_bit))
      else $error("level not copied");

   // timer routes become software traps in watchdog mode
   a_trap_guard: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && guard && !vector_sel_q[0] |=> soft_trap_pend)
      else $error("no soft trap");

   // channel a0 carries the timer when its route bit is clear
   a_a0_timer: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && eoc && !guard && !vector_sel_q[0] |=> channel_a0_irq)
      else $error("missing channel interrupt");

   // top level follows the synchronised pin when selected
   a_top_pin: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && vector_sel_q[1] |=> top_level_irq == $past(nmi_s2_q))
      else $error("top level not from pin");

   // prescaler wraps to its constant on every zero except a single-mode stop
   a_prescale_reload: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && tick && pre_zero && !reload_now && !single_stop
      |=> pre_count_q == $past(pre_const_q)) else $error("prescaler not reloaded");

   // prescaler steps down once per counting clock
   a_prescale_step: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && tick && !pre_zero && !reload_now
      |=> pre_count_q == $past(pre_count_q) - 8'h01) else $error("prescaler did not step");

   // counter steps down once per prescaler wrap
   a_count_step: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && tick && pre_zero && !eoc && !reload_now
      |=> count_q == $past(count_q) - 16'h0001) else $error("counter did not step");
endmodule : timer_watchdog_unit
`default_nettype wire

/* File: test/pin_partner.sv */
`default_nettype none
module pin_partner (
   input wire logic clock,
   input wire logic out_pin,
   input wire logic out_oe,
   output logic in_pin,
   output logic line
);
   timeunit 1ns;
   timeprecision 100ps;
   // the pad has a pull-up, so a released output reads high
   assign line = out_oe ? out_pin : 1'b1;
   initial in_pin = 1'b1;
   // edges kept four clocks apart so the synchroniser never merges two events
   task automatic fall(input int n);
      repeat (n) begin
         repeat (4) @(posedge clock);
         #1 in_pin = 1'b0;
         repeat (4) @(posedge clock);
         #1 in_pin = 1'b1;
      end
   endtask : fall
   task automatic hold(input logic v);
      @(posedge clock);
      #1 in_pin = v;
   endtask : hold
endmodule : pin_partner
`default_nettype wire

/* File: test/testbench.sv */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   timer_watchdog_pkg::reg_write_s reg_wr = '0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_rdata, rv;
   logic in_pin, out_pin, out_oe, line, top_irq, a0_irq, trap, sys_rst, eoc;
   logic ext_pin = 1'b0;
   int bad_count = 0, n_checks = 0, n_eoc = 0, n_irq = 0, n_rst = 0, n_a0 = 0, b, bi, ba;
   always #2.5 clock = ~clock;
   timer_watchdog_unit timer_watchdog_unit_i (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
      .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .timer_in_pin(in_pin),
      .nmi_pin(ext_pin), .ext_a0_pin(ext_pin), .timer_out_pin(out_pin), .timer_out_oe(out_oe),
      .top_level_irq(top_irq), .channel_a0_irq(a0_irq), .soft_trap_pend(trap),
      .system_reset_req(sys_rst), .end_of_count(eoc));
   pin_partner pin_partner_i (.clock(clock), .out_pin(out_pin), .out_oe(out_oe),
      .in_pin(in_pin), .line(line));
   always @(posedge clock) begin
      if (eoc === 1'b1) n_eoc <= n_eoc + 1;
      if (top_irq === 1'b1) n_irq <= n_irq + 1;
      if (a0_irq === 1'b1) n_a0 <= n_a0 + 1;
      if (sys_rst === 1'b1) n_rst <= n_rst + 1;
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #1 reg_wr = '{wr: 1'b1, addr: a, data: d};
      @(posedge clock);
      #1 reg_wr.wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      #1 reg_addr = a;
      repeat (2) @(posedge clock);
      #1 rv = reg_rdata;
   endtask : rd
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick
   // bounded wait, a lost end of count closes the run
   task automatic wait_eoc;
      for (int i = 0; i < 3000 && eoc !== 1'b1; i++) tick(1);
      if (eoc !== 1'b1) begin
         check("end of count wait", 16'h0001, 16'h0000);
         wrap_up();
      end
   endtask : wait_eoc
   task automatic t_reset;
      rd(timer_watchdog_pkg::ADDR_CONTROL);
      check("control reset", 16'h0012, rv);
      rd(timer_watchdog_pkg::ADDR_WAIT_CONTROL);
      check("wait reset", 16'h007f, rv);
      rd(timer_watchdog_pkg::ADDR_VECTOR_SELECT);
      check("vector reset", 16'h0006, 16'(rv & 8'h06));
      rd(8'hf7);
      check("unmapped read", 16'h0000, rv);
      check("idle pin", 16'h0001, 16'(out_pin));
      check("idle line", 16'h0001, 16'(line));
      ext_pin = 1'b1;
      tick(3);
      check("top from pin", 16'h0001, 16'(top_irq));
      check("a0 from pin", 16'h0001, 16'(a0_irq));
      ext_pin = 1'b0;
      tick(3);
      check("top pin low", 16'h0000, 16'(top_irq));
      check("a0 pin low", 16'h0000, 16'(a0_irq));
      $display("test reset done");
   endtask : t_reset
   task automatic t_cont;
      logic p;
      wr(timer_watchdog_pkg::ADDR_VECTOR_SELECT, 8'h00);
      wr(timer_watchdog_pkg::ADDR_PRESCALE, 8'h00);
      wr(timer_watchdog_pkg::ADDR_COUNT_HIGH, 8'h00);
      wr(timer_watchdog_pkg::ADDR_COUNT_LOW, 8'h00);
      wr(timer_watchdog_pkg::ADDR_CONTROL, 8'h81);
      wait_eoc();
      tick(1);
      b = n_eoc;
      bi = n_irq;
      ba = n_a0;
      p = out_pin;
      tick(38);
      check("eoc in window", 16'd9, 16'(n_eoc - b));
      check("irq in window", 16'd9, 16'(n_irq - bi));
      check("a0 irq in window", 16'd9, 16'(n_a0 - ba));
      check("toggled pin", {15'h0000, ~p}, 16'(out_pin));
      for (int l = 0; l < 2; l++) begin
         wr(timer_watchdog_pkg::ADDR_CONTROL, 8'h85 | 8'(l << 1));
         tick(1);
         wait_eoc();
         tick(2);
         check("level pin", 16'(l), 16'(out_pin));
      end
      wr(timer_watchdog_pkg::ADDR_CONTROL, 8'h01);
      tick(1);
      b = n_eoc;
      tick(30);
      check("stopped eoc", 16'd0, 16'(n_eoc - b));
      wr(timer_watchdog_pkg::ADDR_CONTROL, 8'h00);
      tick(2);
      check("disabled pin", 16'h0001, 16'(out_pin));
      $display("test continuous done");
   endtask : t_cont
   task automatic t_single;
      wr(timer_watchdog_pkg::ADDR_CONTROL, 8'hc1);
      wait_eoc();
      tick(3);
      rd(timer_watchdog_pkg::ADDR_CONTROL);
      check("run bit after single", 16'h0000, 16'(rv[7]));
      rd(timer_watchdog_pkg::ADDR_COUNT_LOW);
      check("single count", 16'h0000, 16'(rv));
      b = n_eoc;
      tick(30);
      check("single eoc", 16'd0, 16'(n_eoc - b));
      $display("test single done");
   endtask : t_single
   task automatic t_event;
      wr(timer_watchdog_pkg::ADDR_COUNT_LOW, 8'h03);
      wr(timer_watchdog_pkg::ADDR_CONTROL, 8'h89);
      b = n_eoc;
      pin_partner_i.fall(3);
      tick(10);
      check("event eoc early", 16'd0, 16'(n_eoc - b));
      pin_partner_i.fall(1);
      tick(10);
      check("event eoc", 16'd1, 16'(n_eoc - b));
      $display("test event done");
   endtask : t_event
   task automatic t_modes;
      wr(timer_watchdog_pkg::ADDR_CONTROL, 8'h00);
      wr(timer_watchdog_pkg::ADDR_COUNT_LOW, 8'h03);
      pin_partner_i.hold(1'b0);
      wr(timer_watchdog_pkg::ADDR_CONTROL, 8'h99);
      b = n_eoc;
      tick(40);
      check("gated low eoc", 16'd0, 16'(n_eoc - b));
      pin_partner_i.hold(1'b1);
      b = n_eoc;
      tick(22);
      check("gated high eoc", 16'd1, 16'(n_eoc - b));
      wr(timer_watchdog_pkg::ADDR_CONTROL, 8'h00);
      wr(timer_watchdog_pkg::ADDR_COUNT_LOW, 8'h03);
      wr(timer_watchdog_pkg::ADDR_CONTROL, 8'h39);
      b = n_eoc;
      tick(30);
      check("retrig idle eoc", 16'd0, 16'(n_eoc - b));
      pin_partner_i.fall(1);
      rd(timer_watchdog_pkg::ADDR_CONTROL);
      check("retrig started", 16'h0001, 16'(rv[7]));
      wr(timer_watchdog_pkg::ADDR_CONTROL, 8'h00);
      wr(timer_watchdog_pkg::ADDR_COUNT_LOW, 8'h0f);
      wr(timer_watchdog_pkg::ADDR_CONTROL, 8'ha9);
      b = n_eoc;
      pin_partner_i.fall(10);
      check("trigger restart eoc", 16'd0, 16'(n_eoc - b));
      b = n_eoc;
      tick(80);
      check("trigger eoc", 16'd1, 16'(n_eoc - b));
      $display("test input modes done");
   endtask : t_modes
   task automatic t_guard;
      wr(timer_watchdog_pkg::ADDR_CONTROL, 8'h00);
      wr(timer_watchdog_pkg::ADDR_COUNT_LOW, 8'h0f);
      wr(timer_watchdog_pkg::ADDR_WAIT_CONTROL, 8'h3f);
      rd(timer_watchdog_pkg::ADDR_WAIT_CONTROL);
      check("guard bit", 16'h0000, 16'(rv[6]));
      check("soft trap", 16'h0001, 16'(trap));
      b = n_rst;
      repeat (4) begin
         tick(30);
         wr(timer_watchdog_pkg::ADDR_COUNT_LOW, timer_watchdog_pkg::SERVICE_FIRST);
         wr(timer_watchdog_pkg::ADDR_COUNT_LOW, timer_watchdog_pkg::SERVICE_SECOND);
      end
      check("serviced resets", 16'd0, 16'(n_rst - b));
      wr(timer_watchdog_pkg::ADDR_WAIT_CONTROL, 8'h7f);
      b = n_rst;
      tick(70);
      check("timeout resets", 16'd1, 16'(n_rst - b));
      rd(timer_watchdog_pkg::ADDR_WAIT_CONTROL);
      check("guard sticky", 16'h0000, 16'(rv[6]));
      rst_n = 1'b0;
      tick(2);
      check("oe in reset", 16'h0000, 16'(out_oe));
      check("line in reset", 16'h0001, 16'(line));
      rst_n = 1'b1;
      rd(timer_watchdog_pkg::ADDR_WAIT_CONTROL);
      check("guard after reset", 16'h0001, 16'(rv[6]));
      check("trap after reset", 16'h0000, 16'(trap));
      $display("test watchdog done");
   endtask : t_guard
   initial begin
      tick(16);
      rst_n = 1'b1;
      t_reset();
      t_cont();
      t_single();
      t_event();
      t_modes();
      t_guard();
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
